// ---- bench/dfm_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// disk controller and positioner lines
// ----------------------------------------
module dfm_ctl_model (
	input wire logic [3:0] op_i,
	output logic erase_o,
	output logic rec_n_o,
	output logic parked_o,
	output logic outer_o,
	output logic cmd_o
);
	// op bits: write, withhold record enable, parked, dead lamp
	// during a write, record enable only goes missing when a scenario injects it
	assign erase_o = op_i[0];
	assign rec_n_o = !(op_i[0] && !op_i[1]);
	assign parked_o = op_i[2];
	assign outer_o = op_i[2] && !op_i[3]; // a dead lamp never sees the outer limit
	assign cmd_o = 1'b1; // commands always offered, so blocking shows
endmodule // dfm_ctl_model
`default_nettype wire

// ---- bench/dfm_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checks for the fault monitor
// ----------------------------------------
module dfm_top_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic erase_current_i,
	input wire logic record_enable_n_i,
	input wire logic heads_parked_i,
	input wire logic past_outer_track_i,
	input wire logic power_on_cycle_i,
	input wire logic cmd_valid_o,
	input wire logic head_upper_en_o,
	input wire logic head_lower_en_o,
	input wire logic fault_lamp_o,
	input wire logic fault_report_o,
	input wire logic unsafe_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// pin levels held long enough to pass the input filter
	sequence s_bad_write;
		(erase_current_i && record_enable_n_i)[*6];
	endsequence
	sequence s_dead_lamp;
		(heads_parked_i && !past_outer_track_i && power_on_cycle_i)[*6];
	endsequence
	AST_BAD_WRITE: assert property (s_bad_write |-> ##[0:6] fault_report_o)
		else $error("bad write not latched");
	AST_GOOD_WRITE: assert property ((!record_enable_n_i)[*8] ##0 !fault_report_o |-> unsafe_n_o)
		else $error("unsafe during enabled write");
	AST_UNSAFE_LATCH: assert property ($fell(unsafe_n_o) |-> ##[0:2] fault_report_o)
		else $error("unsafe without report");
	AST_LAMP_TIE: assert property (fault_lamp_o == fault_report_o)
		else $error("lamp and report differ");
	AST_HEADS_OFF: assert property (!unsafe_n_o |-> !head_upper_en_o && !head_lower_en_o)
		else $error("head selected while unsafe");
	AST_LAMP_DEAD: assert property (s_dead_lamp |-> ##[0:6] fault_lamp_o)
		else $error("dead lamp not latched");
	AST_CMD_BLOCK: assert property (fault_report_o && $past(fault_report_o) |-> !cmd_valid_o)
		else $error("command passed during fault");
	AST_LATCH_HOLD: assert property (fault_report_o |=> fault_report_o)
		else $error("fault latch dropped");
endmodule // dfm_top_asserts
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, power_on_cycle_i, irq_o;
	logic erase_current_i, record_enable_n_i, heads_parked_i, past_outer_track_i, cmd_valid_i;
	logic cmd_valid_o, head_upper_en_o, head_lower_en_o, fault_lamp_o, fault_report_o, unsafe_n_o;
	logic [3:0] wb_adr_i, wb_sel_i, op;
	logic [31:0] wb_dat_i, wb_dat_o, rdat;
	int n_errors = 0;
	int n_checks = 0;
	int ticks = 0;
	typedef struct packed {logic [3:0] op; logic pwr; logic exp;} dfm_row_t;
	// op, power-on cycle, expected fault
	dfm_row_t rows [5] = '{6'h04, 6'h12, 6'h30, 6'h33, 6'h0d};
	dfm_top dfm_top_i (.*, .head_upper_sel_i(1'b1), .head_lower_sel_i(1'b1));
	dfm_ctl_model dfm_ctl_model_i (.op_i(op), .erase_o(erase_current_i),
		.rec_n_o(record_enable_n_i), .parked_o(heads_parked_i),
		.outer_o(past_outer_track_i), .cmd_o(cmd_valid_i));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// hang guard, far above the fewer than two hundred cycles needed
	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 2000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic do_reset(int n);
		rst_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	task automatic run(logic [3:0] o, int n);
		op <= o;
		repeat (n) @(posedge clk_i);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		op <= 4'h0;
		power_on_cycle_i <= 1'b0;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_adr_i <= 4'h0;
		wb_sel_i <= 4'hf;
		wb_dat_i <= 32'h0;
		do_reset(12);
		foreach (rows[i]) begin
			do_reset(2);
			power_on_cycle_i <= rows[i].pwr;
			run(rows[i].op, 12);
			chk("report", rows[i].exp, fault_report_o);
			chk("lamp", rows[i].exp, fault_lamp_o);
		end
		// heads loaded, then drifting home with a dead lamp
		do_reset(2);
		power_on_cycle_i <= 1'b0;
		run(4'hc, 12);
		run(4'h0, 12);
		run(4'hc, 12);
		chk("drift", 1, fault_report_o);
		run(4'h0, 12);
		chk("hold", 1, fault_report_o);
		chk("cmd", 0, cmd_valid_o);
		// current fault, then the interrupt path
		do_reset(2);
		run(4'h3, 12);
		chk("heads", 0, {head_upper_en_o, head_lower_en_o});
		chk("unsafe", 0, unsafe_n_o);
		chk("irq_masked", 0, irq_o);
		run(4'h0, 12);
		wb(1'b1, 4'h8, 32'h1);
		chk("irq_on", 1, irq_o);
		wb(1'b0, 4'h0, 32'h0);
		chk("status", 32'h5, rdat);
		wb(1'b1, 4'h4, 32'h1);
		chk("irq_clr", 0, irq_o);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped", 0, rdat);
		give_verdict();
	end
endmodule // testbench
bind dfm_top dfm_top_asserts dfm_top_asserts_i (.*);
`default_nettype wire

// ---- core/dfm_cfg.svh ----
`ifndef DFM_CFG_SVH
`define DFM_CFG_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define DFM_ADDR_STATUS 4'h0
`define DFM_ADDR_IRQ_STAT 4'h4
`define DFM_ADDR_IRQ_MASK 4'h8
`define DFM_ADDR_CTRL 4'hc
// ----------------------------------------
// field positions and resets
// ----------------------------------------
`define DFM_BIT_CURRENT 0
`define DFM_BIT_LAMP 1
`define DFM_BIT_LATCH 2
`define DFM_BIT_PARKED 3
`define DFM_BIT_CHECK_EN 0
`define DFM_MASK_RESET 2'h0
`define DFM_CTRL_RESET 1'h1
// ----------------------------------------
// timing counts
// ----------------------------------------
// edges after reset before the pin filter shows real levels
`define DFM_SETTLE_CYCLES 3'h4
`endif

// ---- core/dfm_pkg.sv ----
package dfm_pkg;
	typedef enum logic [1:0] {
		DFM_IDLE,
		DFM_RUN,
		DFM_TRIPPED
	} dfm_state_t;
	typedef logic [1:0] dfm_cause_t;
endpackage

// ---- core/dfm_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module dfm_sync #(
	parameter int W = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	dfm_sync_if.sync s
);
	logic [W-1:0] st1;
	logic [W-1:0] st2;
	logic [W-1:0] st3;
	logic [W-1:0] held;
	// a zero-wide bus leaves nothing to filter
	if (W < 1) begin : g_bad_w
		$error("dfm_sync needs W of at least 1");
	end
	// ----------------------------------------
	// three stages, accept when 2 and 3 agree
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st1 <= '0;
			st2 <= '0;
			st3 <= '0;
		end else begin
			st1 <= s.raw;
			st2 <= st1;
			st3 <= st2;
		end
	end
	// per-bit agreement filter, stage 1 never looked at
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			held <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (st2[i] == st3[i]) begin
					held[i] <= st3[i];
				end
			end
		end
	end
	assign s.clean = held;
endmodule // dfm_sync
`default_nettype wire

// ---- core/dfm_sync_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dfm_sync_if #(parameter int W = 4);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface
`default_nettype wire

// ---- core/dfm_top.sv ----
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dfm_cfg.svh"
module dfm_top (
	input wire logic clk_i,
	input wire logic rst_i,
	// classic wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// drive side pins
	input wire logic erase_current_i,
	input wire logic record_enable_n_i,
	input wire logic heads_parked_i,
	input wire logic past_outer_track_i,
	input wire logic power_on_cycle_i,
	input wire logic cmd_valid_i,
	input wire logic head_upper_sel_i,
	input wire logic head_lower_sel_i,
	output logic cmd_valid_o,
	output logic head_upper_en_o,
	output logic head_lower_en_o,
	output logic fault_lamp_o,
	output logic fault_report_o,
	output logic unsafe_n_o,
	output logic irq_o
);
	localparam int NSYNC = 4;
	dfm_sync_if #(.W(NSYNC)) pins ();
	logic erase_s;
	logic rec_n_s;
	logic parked_s;
	logic outer_s;
	logic loaded_seen;
	logic check_en;
	logic fault_latch;
	logic [1:0] cause;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic set_unsafe;
	logic lamp_fault;
	logic bus_req;
	logic bus_wr;
	logic [2:0] settle_cnt;
	logic fault_any;
	logic current_any;
	dfm_pkg::dfm_state_t state;
	// ----------------------------------------
	// shared decode
	// ----------------------------------------
	// one register decode, shared by the write paths; the read path decodes with its own case
	function automatic logic dfm_hit(input logic [3:0] adr, input logic [3:0] reg_adr);
		return adr == reg_adr;
	endfunction
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	assign pins.raw = {past_outer_track_i, heads_parked_i, record_enable_n_i, erase_current_i};
	dfm_sync #(.W(NSYNC)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.s(pins)
	);
	assign erase_s = pins.clean[0];
	assign rec_n_s = pins.clean[1];
	assign parked_s = pins.clean[2];
	assign outer_s = pins.clean[3];
	// ----------------------------------------
	// fault detection
	// ----------------------------------------
	// current without record enable; record enable masks it
	assign set_unsafe = erase_s & rec_n_s;
	// parked but lamp gives no past-outer-track reading
	assign lamp_fault = check_en & parked_s & ~outer_s
		& (power_on_cycle_i | loaded_seen);
	// count out the filter fill; its reset zeros look like unparked heads
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settle_cnt <= 3'h0;
		end else if (settle_cnt != `DFM_SETTLE_CYCLES) begin
			settle_cnt <= settle_cnt + 3'h1;
		end
	end
	// remember that heads left park once, so a drift back is checked
	// only trusted after warm-up, else reset itself would look like a load
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loaded_seen <= 1'b0;
		end else if (state == dfm_pkg::DFM_RUN && !parked_s) begin
			loaded_seen <= 1'b1;
		end
	end
	// state of the monitor; tripped only leaves by reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= dfm_pkg::DFM_IDLE;
		end else begin
			case (state)
				dfm_pkg::DFM_IDLE: begin
					if (settle_cnt == `DFM_SETTLE_CYCLES) begin
						state <= dfm_pkg::DFM_RUN;
					end
				end
				dfm_pkg::DFM_RUN: begin
					if (set_unsafe || lamp_fault) begin
						state <= dfm_pkg::DFM_TRIPPED;
					end
				end
				dfm_pkg::DFM_TRIPPED: state <= dfm_pkg::DFM_TRIPPED;
				default: state <= dfm_pkg::DFM_IDLE;
			endcase
		end
	end
	// fault latch and cause record, set only, cleared by reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_latch <= 1'b0;
			cause <= 2'h0;
		end else begin
			if (set_unsafe || lamp_fault) begin
				fault_latch <= 1'b1;
			end
			if (set_unsafe) begin
				cause[`DFM_BIT_CURRENT] <= 1'b1;
			end
			if (lamp_fault) begin
				cause[`DFM_BIT_LAMP] <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// drive outputs, registered
	// ----------------------------------------
	// raw triggers are folded in so outputs react the same cycle as the latch, except unsafe and heads on a lamp fault
	assign fault_any = fault_latch | set_unsafe | lamp_fault;
	assign current_any = fault_latch | set_unsafe;
	// panel lamp
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_lamp_o <= 1'b0;
		end else begin
			fault_lamp_o <= fault_any;
		end
	end
	// fault report toward the controller
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_report_o <= 1'b0;
		end else begin
			fault_report_o <= fault_any;
		end
	end
	// unsafe trigger, high while no current fault and no fault of either kind latched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unsafe_n_o <= 1'b1;
		end else begin
			unsafe_n_o <= ~current_any;
		end
	end
	// a current fault drops both heads at once, not a cycle late
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			head_upper_en_o <= 1'b0;
		end else begin
			head_upper_en_o <= head_upper_sel_i & ~current_any;
		end
	end
	// lower head, same gating as the upper
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			head_lower_en_o <= 1'b0;
		end else begin
			head_lower_en_o <= head_lower_sel_i & ~current_any;
		end
	end
	// outside commands pass one clock late, blocked by any fault
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_valid_o <= 1'b0;
		end else begin
			cmd_valid_o <= cmd_valid_i & ~fault_any;
		end
	end
	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	// set beats a write-one clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (bus_wr && dfm_hit(wb_adr_i, `DFM_ADDR_IRQ_STAT) && wb_sel_i[0] && wb_dat_i[i]) begin
					irq_stat[i] <= 1'b0;
				end
				if ((i == `DFM_BIT_CURRENT && set_unsafe) || (i == `DFM_BIT_LAMP && lamp_fault)) begin
					irq_stat[i] <= 1'b1;
				end
			end
		end
	end
	assign irq_o = |(irq_stat & irq_mask);
	// ----------------------------------------
	// wishbone slave, one wait state
	// ----------------------------------------
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr = bus_req & wb_we_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end
	// writable registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask <= `DFM_MASK_RESET;
			check_en <= `DFM_CTRL_RESET;
		end else if (bus_wr && wb_sel_i[0]) begin
			if (dfm_hit(wb_adr_i, `DFM_ADDR_IRQ_MASK)) begin
				irq_mask <= wb_dat_i[1:0];
			end
			if (dfm_hit(wb_adr_i, `DFM_ADDR_CTRL)) begin
				check_en <= wb_dat_i[`DFM_BIT_CHECK_EN];
			end
		end
	end
	// read data; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				`DFM_ADDR_STATUS: wb_dat_o <= {28'h0, parked_s, fault_latch, cause};
				`DFM_ADDR_IRQ_STAT: wb_dat_o <= {30'h0, irq_stat};
				`DFM_ADDR_IRQ_MASK: wb_dat_o <= {30'h0, irq_mask};
				`DFM_ADDR_CTRL: wb_dat_o <= {31'h0, check_en};
				default: wb_dat_o <= 32'h0;
			endcase
		end
	end
endmodule // dfm_top
`default_nettype wire
